// file: hw/bank_one_sfr_regs.svh
// register indices, field masks and reset values of the bank one register map
`ifndef BANK_ONE_SFR_REGS_SVH
`define BANK_ONE_SFR_REGS_SVH
`define IDX_INDIRECT      9'h080
`define IDX_OPTION        9'h081
`define IDX_PCL           9'h082
`define IDX_STATUS        9'h083
`define IDX_FSR           9'h084
`define IDX_PORT_A_DIRECTION         9'h085
`define IDX_PORT_B_DIRECTION         9'h086
`define IDX_PROGRAM_COUNTER_HIGH_BUFFER        9'h08A
`define IDX_CORE_INTERRUPT_CONTROL        9'h08B
`define IDX_PERIPHERAL_IRQ_ENABLE_ONE          9'h08C
`define IDX_PERIPHERAL_IRQ_ENABLE_TWO          9'h08D
`define IDX_RESET_CAUSE_FLAGS          9'h08E
`define IDX_OSCILLATOR_SELECT        9'h08F
`define IDX_INTERNAL_OSC_TRIM       9'h090
`define IDX_PR2           9'h092
`define IDX_SERIAL_PORT_SLAVE_ADDRESS        9'h093
`define IDX_SERIAL_PORT_FLAGS       9'h094
`define IDX_CONVERSION_RESULT_LOW        9'h09E
`define IDX_CONVERSION_CONFIG_ONE        9'h09F
`define BANK_ONE          2'h1
`define BANK_LSB          7
`define PIN_FIVE          5
`define IRP_BIT           7
`define MASK_ALL          8'hFF
`define MASK_STATUS_SW    8'hE7
`define MASK_PROGRAM_COUNTER_HIGH_BUFFER       8'h1F
`define MASK_PERIPHERAL_IRQ_ENABLE_ONE         8'h4F
`define MASK_PERIPHERAL_IRQ_ENABLE_TWO         8'h10
`define MASK_RESET_CAUSE_FLAGS         8'h03
`define MASK_OSCILLATOR_SELECT_SW    8'h70
`define BIT_IOFS          2
`define MASK_INTERNAL_OSC_TRIM      8'h3F
`define MASK_SERIAL_PORT_FLAGS_SW   8'hC0
`define MASK_CONVERSION_CONFIG_ONE       8'hCF
`define RST_ONES          8'hFF
`define RST_ZERO          8'h00
`define RST_STATUS_HI     5'h03
`define RST_CORE_INTERRUPT_CONTROL_HI     7'h00
`define RST_PC            13'h0000
`endif

// file: hw/bank_one_sfr_pkg.sv
// shared types of the bank one register map
package bank_one_sfr_pkg;
  typedef logic [7:0] sfr_byte_type;
  typedef logic [8:0] sfr_index_type;
  typedef logic [12:0] pc_word_type;
endpackage

// file: hw/pc_unit.sv
// program counter with upper bits loaded from the high-address buffer
`timescale 1ns/1ps
`include "bank_one_sfr_regs.svh"
module pc_unit
  import bank_one_sfr_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         pcl_write,
  input  wire sfr_byte_type pcl_data,
  input  wire sfr_byte_type program_counter_high_buffer,
  input  wire logic         jump_load,
  input  wire logic [10:0]  jump_target,
  input  wire logic         step,
  output logic [12:0]       program_counter
);
  pc_word_type pc_q;
  pc_word_type pc_d;

  // ********************************
  // counter update
  // ********************************
  always_comb begin
    pc_d = pc_q;
    if (pcl_write) begin
      pc_d = {program_counter_high_buffer[4:0], pcl_data};
    end else if (jump_load) begin
      pc_d = {program_counter_high_buffer[4:3], jump_target};
    end else if (step) begin
      pc_d = pc_q + 13'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pc_q <= `RST_PC;
    end else begin
      pc_q <= pc_d;
    end
  end

  assign program_counter = pc_q;
endmodule

// file: hw/bank_one_sfr_map.sv
// bank one special function register map behind an apb slave
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "bank_one_sfr_regs.svh"

module bank_one_sfr_map
  import bank_one_sfr_pkg::*;
#(
  parameter int ADDR_WIDTH = 12
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  reset_is_brown_out,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_WIDTH-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire sfr_byte_type          indirect_rdata,
  output logic [8:0]                 indirect_address,
  output logic                       indirect_write,
  output sfr_byte_type               indirect_wdata,
  input  wire logic                  alu_flags_we,
  input  wire logic [2:0]            alu_flags,
  input  wire logic                  power_flags_we,
  input  wire logic [1:0]            power_flags,
  input  wire logic                  osc_stable,
  input  wire logic [5:0]            serial_status,
  input  wire logic                  conv_done,
  input  wire sfr_byte_type          conv_result_low,
  input  wire logic                  jump_load,
  input  wire logic [10:0]           jump_target,
  input  wire logic                  pc_step,
  output logic [12:0]                program_counter,
  output logic [7:0]                 port_a_drive_en,
  output logic [7:0]                 port_b_drive_en,
  output sfr_byte_type               timer_prescale_settings,
  output sfr_byte_type               core_flags_bank_select,
  output sfr_byte_type               core_interrupt_control,
  output sfr_byte_type               peripheral_irq_enable_one,
  output sfr_byte_type               peripheral_irq_enable_two,
  output sfr_byte_type               oscillator_select,
  output sfr_byte_type               internal_osc_trim,
  output sfr_byte_type               timer_two_period,
  output sfr_byte_type               serial_port_slave_address,
  output sfr_byte_type               conversion_config_one
);
  sfr_index_type idx;
  logic          wr;
  logic          setup;
  sfr_byte_type  wd;
  sfr_byte_type  rd;
  sfr_byte_type  option_q, option_d, status_q, status_d, fsr_q, fsr_d;
  sfr_byte_type  port_a_direction_q, port_a_direction_d, port_b_direction_q, port_b_direction_d, program_counter_high_buffer_q, program_counter_high_buffer_d;
  sfr_byte_type  core_interrupt_control_q, core_interrupt_control_d, peripheral_irq_enable_one_q, peripheral_irq_enable_one_d, peripheral_irq_enable_two_q, peripheral_irq_enable_two_d;
  sfr_byte_type  reset_cause_flags_q, reset_cause_flags_d, oscillator_select_q, oscillator_select_d, internal_osc_trim_q, internal_osc_trim_d;
  sfr_byte_type  pr2_q, pr2_d, serial_port_slave_address_q, serial_port_slave_address_d, serial_port_flags_q, serial_port_flags_d;
  sfr_byte_type  conversion_result_low_q, conversion_result_low_d, conversion_config_one_q, conversion_config_one_d;
  sfr_byte_type  prdata_q, prdata_d, indw_d;
  logic          indwr_q, indwr_d;
  logic          pcl_write;

  // ********************************
  // address decode
  // ********************************
  assign idx      = paddr[10:2];
  assign setup    = psel && !penable;
  assign wr       = psel && penable && pwrite && pready;
  assign wd       = pwdata[7:0];

  // shared locations match their low seven bits in any bank
  function automatic logic hit(input sfr_index_type a, input sfr_index_type r, input logic shared);
    if (shared) begin
      hit = (a[6:0] == r[6:0]);
    end else begin
      hit = (a[8:`BANK_LSB] == `BANK_ONE) && (a[6:0] == r[6:0]);
    end
  endfunction

  assign pcl_write = wr && hit(idx, `IDX_PCL, 1'b1);
  // ********************************
  // register next values
  // ********************************
  always_comb begin
    option_d  = option_q;
    status_d  = status_q;
    fsr_d     = fsr_q;
    port_a_direction_d   = port_a_direction_q;
    port_b_direction_d   = port_b_direction_q;
    program_counter_high_buffer_d  = program_counter_high_buffer_q;
    core_interrupt_control_d  = core_interrupt_control_q;
    peripheral_irq_enable_one_d    = peripheral_irq_enable_one_q;
    peripheral_irq_enable_two_d    = peripheral_irq_enable_two_q;
    reset_cause_flags_d    = reset_cause_flags_q;
    oscillator_select_d  = oscillator_select_q;
    internal_osc_trim_d = internal_osc_trim_q;
    pr2_d     = pr2_q;
    serial_port_slave_address_d  = serial_port_slave_address_q;
    serial_port_flags_d = {serial_port_flags_q[7:6], serial_status};
    conversion_result_low_d  = conversion_result_low_q;
    conversion_config_one_d  = conversion_config_one_q;
    indwr_d   = 1'b0;
    indw_d    = indirect_wdata;
    oscillator_select_d[`BIT_IOFS] = osc_stable;
    if (alu_flags_we) begin
      status_d[2:0] = alu_flags;
    end
    if (power_flags_we) begin
      status_d[4:3] = power_flags;
    end
    if (conv_done) begin
      conversion_result_low_d = conv_result_low;
    end
    if (wr) begin
      if (hit(idx, `IDX_INDIRECT, 1'b1)) begin
        indwr_d = 1'b1;
        indw_d  = wd;
      end else if (hit(idx, `IDX_STATUS, 1'b1)) begin
        status_d = (status_d & ~`MASK_STATUS_SW) | (wd & `MASK_STATUS_SW);
      end else if (hit(idx, `IDX_FSR, 1'b1)) begin
        fsr_d = wd;
      end else if (hit(idx, `IDX_PROGRAM_COUNTER_HIGH_BUFFER, 1'b1)) begin
        program_counter_high_buffer_d = wd & `MASK_PROGRAM_COUNTER_HIGH_BUFFER;
      end else if (hit(idx, `IDX_CORE_INTERRUPT_CONTROL, 1'b1)) begin
        core_interrupt_control_d = wd;
      end else if (hit(idx, `IDX_OPTION, 1'b0)) begin
        option_d = wd;
      end else if (hit(idx, `IDX_PORT_A_DIRECTION, 1'b0)) begin
        port_a_direction_d = wd;
      end else if (hit(idx, `IDX_PORT_B_DIRECTION, 1'b0)) begin
        port_b_direction_d = wd;
      end else if (hit(idx, `IDX_PERIPHERAL_IRQ_ENABLE_ONE, 1'b0)) begin
        peripheral_irq_enable_one_d = wd & `MASK_PERIPHERAL_IRQ_ENABLE_ONE;
      end else if (hit(idx, `IDX_PERIPHERAL_IRQ_ENABLE_TWO, 1'b0)) begin
        peripheral_irq_enable_two_d = wd & `MASK_PERIPHERAL_IRQ_ENABLE_TWO;
      end else if (hit(idx, `IDX_RESET_CAUSE_FLAGS, 1'b0)) begin
        reset_cause_flags_d = wd & `MASK_RESET_CAUSE_FLAGS;
      end else if (hit(idx, `IDX_OSCILLATOR_SELECT, 1'b0)) begin
        oscillator_select_d = (oscillator_select_d & ~`MASK_OSCILLATOR_SELECT_SW) | (wd & `MASK_OSCILLATOR_SELECT_SW);
      end else if (hit(idx, `IDX_INTERNAL_OSC_TRIM, 1'b0)) begin
        internal_osc_trim_d = wd & `MASK_INTERNAL_OSC_TRIM;
      end else if (hit(idx, `IDX_PR2, 1'b0)) begin
        pr2_d = wd;
      end else if (hit(idx, `IDX_SERIAL_PORT_SLAVE_ADDRESS, 1'b0)) begin
        serial_port_slave_address_d = wd;
      end else if (hit(idx, `IDX_SERIAL_PORT_FLAGS, 1'b0)) begin
        serial_port_flags_d = (serial_port_flags_d & ~`MASK_SERIAL_PORT_FLAGS_SW) | (wd & `MASK_SERIAL_PORT_FLAGS_SW);
      end else if (hit(idx, `IDX_CONVERSION_RESULT_LOW, 1'b0)) begin
        conversion_result_low_d = wd;
      end else if (hit(idx, `IDX_CONVERSION_CONFIG_ONE, 1'b0)) begin
        conversion_config_one_d = wd & `MASK_CONVERSION_CONFIG_ONE;
      end
    end
    port_a_direction_d[`PIN_FIVE] = 1'b1;
  end

  // ********************************
  // read data, captured in the setup cycle
  // ********************************
  always_comb begin
    rd = `RST_ZERO;
    if (hit(idx, `IDX_INDIRECT, 1'b1)) begin
      rd = indirect_rdata;
    end else if (hit(idx, `IDX_PCL, 1'b1)) begin
      rd = program_counter[7:0];
    end else if (hit(idx, `IDX_STATUS, 1'b1)) begin
      rd = status_q;
    end else if (hit(idx, `IDX_FSR, 1'b1)) begin
      rd = fsr_q;
    end else if (hit(idx, `IDX_PROGRAM_COUNTER_HIGH_BUFFER, 1'b1)) begin
      rd = program_counter_high_buffer_q;
    end else if (hit(idx, `IDX_CORE_INTERRUPT_CONTROL, 1'b1)) begin
      rd = core_interrupt_control_q;
    end else if (idx == `IDX_OPTION) begin
      rd = option_q;
    end else if (idx == `IDX_PORT_A_DIRECTION) begin
      rd = port_a_direction_q;
    end else if (idx == `IDX_PORT_B_DIRECTION) begin
      rd = port_b_direction_q;
    end else if (idx == `IDX_PERIPHERAL_IRQ_ENABLE_ONE) begin
      rd = peripheral_irq_enable_one_q;
    end else if (idx == `IDX_PERIPHERAL_IRQ_ENABLE_TWO) begin
      rd = peripheral_irq_enable_two_q;
    end else if (idx == `IDX_RESET_CAUSE_FLAGS) begin
      rd = reset_cause_flags_q;
    end else if (idx == `IDX_OSCILLATOR_SELECT) begin
      rd = oscillator_select_q;
    end else if (idx == `IDX_INTERNAL_OSC_TRIM) begin
      rd = internal_osc_trim_q;
    end else if (idx == `IDX_PR2) begin
      rd = pr2_q;
    end else if (idx == `IDX_SERIAL_PORT_SLAVE_ADDRESS) begin
      rd = serial_port_slave_address_q;
    end else if (idx == `IDX_SERIAL_PORT_FLAGS) begin
      rd = serial_port_flags_q;
    end else if (idx == `IDX_CONVERSION_RESULT_LOW) begin
      rd = conversion_result_low_q;
    end else if (idx == `IDX_CONVERSION_CONFIG_ONE) begin
      rd = conversion_config_one_q;
    end
    prdata_d = prdata_q;
    if (setup && !pwrite) begin
      prdata_d = rd;
    end
  end

  // ********************************
  // registers
  // ********************************
  always_ff @(posedge clk) begin
    if (rst) begin
      option_q           <= `RST_ONES;
      port_a_direction_q            <= `RST_ONES;
      port_b_direction_q            <= `RST_ONES;
      pr2_q              <= `RST_ONES;
      status_q[7:3]      <= `RST_STATUS_HI;
      status_q[2:0]      <= status_d[2:0];
      core_interrupt_control_q[7:1]      <= `RST_CORE_INTERRUPT_CONTROL_HI;
      core_interrupt_control_q[0]        <= core_interrupt_control_d[0];
      fsr_q              <= fsr_d;
      conversion_result_low_q           <= conversion_result_low_d;
      program_counter_high_buffer_q           <= `RST_ZERO;
      peripheral_irq_enable_one_q             <= `RST_ZERO;
      peripheral_irq_enable_two_q             <= `RST_ZERO;
      reset_cause_flags_q             <= {6'h00, reset_is_brown_out, !reset_is_brown_out};
      oscillator_select_q           <= `RST_ZERO;
      internal_osc_trim_q          <= `RST_ZERO;
      serial_port_slave_address_q           <= `RST_ZERO;
      serial_port_flags_q          <= `RST_ZERO;
      conversion_config_one_q           <= `RST_ZERO;
      prdata_q           <= `RST_ZERO;
      indwr_q            <= 1'b0;
      indirect_wdata     <= `RST_ZERO;
    end else begin
      option_q           <= option_d;
      port_a_direction_q            <= port_a_direction_d;
      port_b_direction_q            <= port_b_direction_d;
      pr2_q              <= pr2_d;
      status_q           <= status_d;
      core_interrupt_control_q           <= core_interrupt_control_d;
      fsr_q              <= fsr_d;
      conversion_result_low_q           <= conversion_result_low_d;
      program_counter_high_buffer_q           <= program_counter_high_buffer_d;
      peripheral_irq_enable_one_q             <= peripheral_irq_enable_one_d;
      peripheral_irq_enable_two_q             <= peripheral_irq_enable_two_d;
      reset_cause_flags_q             <= reset_cause_flags_d;
      oscillator_select_q           <= oscillator_select_d;
      internal_osc_trim_q          <= internal_osc_trim_d;
      serial_port_slave_address_q           <= serial_port_slave_address_d;
      serial_port_flags_q          <= serial_port_flags_d;
      conversion_config_one_q           <= conversion_config_one_d;
      prdata_q           <= prdata_d;
      indwr_q            <= indwr_d;
      indirect_wdata     <= indw_d;
    end
  end
  pc_unit u_pc (
    .clk             (clk),
    .rst             (rst),
    .pcl_write       (pcl_write),
    .pcl_data        (wd),
    .program_counter_high_buffer          (program_counter_high_buffer_q),
    .jump_load       (jump_load),
    .jump_target     (jump_target),
    .step            (pc_step),
    .program_counter (program_counter)
  );

  // ********************************
  // outputs
  // ********************************
  assign pready           = 1'b1;
  assign pslverr          = 1'b0;
  assign prdata           = {24'h000000, prdata_q};
  assign indirect_write   = indwr_q;
  assign indirect_address = {status_q[`IRP_BIT], fsr_q};
  assign port_a_drive_en  = ~port_a_direction_q & ~(8'h01 << `PIN_FIVE);
  assign port_b_drive_en  = ~port_b_direction_q;
  assign timer_prescale_settings   = option_q;
  assign core_flags_bank_select    = status_q;
  assign core_interrupt_control    = core_interrupt_control_q;
  assign peripheral_irq_enable_one = peripheral_irq_enable_one_q;
  assign peripheral_irq_enable_two = peripheral_irq_enable_two_q;
  assign oscillator_select         = oscillator_select_q;
  assign internal_osc_trim         = internal_osc_trim_q;
  assign timer_two_period          = pr2_q;
  assign serial_port_slave_address = serial_port_slave_address_q;
  assign conversion_config_one     = conversion_config_one_q;

  // ********************************
  // checks
  // ********************************
  sequence read_setup(logic [8:0] i);
    psel && !penable && !pwrite && idx == i;
  endsequence
  sequence write_access(logic [8:0] i);
    psel && penable && pwrite && idx == i;
  endsequence
  a_pin_five_read: assert property (@(posedge clk) disable iff (rst)
    read_setup(`IDX_PORT_A_DIRECTION) |=> prdata[`PIN_FIVE])
    else $error("pin five direction bit did not read one");
  a_pin_five_drive: assert property (@(posedge clk) disable iff (rst)
    !port_a_drive_en[`PIN_FIVE])
    else $error("pin five output driver enabled");
  a_unmapped_zero: assert property (@(posedge clk) disable iff (rst)
    read_setup(9'h091) |=> prdata == 32'h00000000)
    else $error("unimplemented address read nonzero");
  a_pie_masked: assert property (@(posedge clk) disable iff (rst)
    write_access(`IDX_PERIPHERAL_IRQ_ENABLE_ONE) |=> peripheral_irq_enable_one_q == ($past(pwdata[7:0]) & `MASK_PERIPHERAL_IRQ_ENABLE_ONE))
    else $error("unimplemented enable bits not zero");
  a_shared_alias: assert property (@(posedge clk) disable iff (rst)
    write_access(9'h004) |=> fsr_q == $past(pwdata[7:0]))
    else $error("pointer write from bank zero missed shared storage");
  a_program_counter_high_buffer_copy: assert property (@(posedge clk) disable iff (rst)
    pcl_write |=> program_counter == {$past(program_counter_high_buffer_q[4:0]), $past(pwdata[7:0])})
    else $error("counter upper bits not taken from buffer");
  a_buffer_only: assert property (@(posedge clk) disable iff (rst)
    read_setup(`IDX_PROGRAM_COUNTER_HIGH_BUFFER) |=> prdata[7:5] == 3'h0 ##0 prdata[4:0] == program_counter_high_buffer_q[4:0])
    else $error("high buffer read exposed counter bits");
  a_reset_ones: assert property (@(posedge clk)
    $fell(rst) |-> option_q == `RST_ONES && port_b_direction_q == `RST_ONES && pr2_q == `RST_ONES)
    else $error("reset did not set ones registers");
  a_reset_cause: assert property (@(posedge clk)
    $fell(rst) |-> reset_cause_flags_q[1:0] == {$past(reset_is_brown_out), !$past(reset_is_brown_out)})
    else $error("reset cause bits wrong");
endmodule

// file: bench/bank_one_sfr_map_tb_top.sv
// self-checking testbench of the bank one register map
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin mismatches++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module bank_one_sfr_map_tb_top;
  import bank_one_sfr_pkg::*;
  // ************************************************************
  // signals and model
  // ************************************************************
  logic               clk;
  logic               rst;
  logic               reset_is_brown_out;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic [11:0]        paddr;
  logic [31:0]        pwdata;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  sfr_byte_type       indirect_rdata;
  logic [8:0]         indirect_address;
  logic               indirect_write;
  sfr_byte_type       indirect_wdata;
  logic               alu_flags_we;
  logic [2:0]         alu_flags;
  logic               power_flags_we;
  logic [1:0]         power_flags;
  logic               osc_stable;
  logic [5:0]         serial_status;
  logic               conv_done;
  sfr_byte_type       conv_result_low;
  logic               jump_load;
  logic [10:0]        jump_target;
  logic               pc_step;
  logic [12:0]        program_counter;
  logic [7:0]         port_a_drive_en;
  logic [7:0]         port_b_drive_en;
  sfr_byte_type       o_b [10];
  logic [7:0]         m [32];
  logic [7:0]         kn [32];
  logic [12:0]        pcm;
  int                 mismatches;
  int                 cmp_count;
  int                 cycles;
  localparam logic [7:0] wr_mask [32] = '{8'h00, 8'hFF, 8'h00, 8'hE7, 8'hFF, 8'hDF, 8'hFF, 8'h00, 8'h00, 8'h00,
    8'h1F, 8'hFF, 8'h4F, 8'h10, 8'h03, 8'h70, 8'h3F, 8'h00, 8'hFF, 8'hFF, 8'hC0, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hCF};
  localparam logic [7:0] rst_val [32] = '{8'h00, 8'hFF, 8'h00, 8'h18, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam int shared_idx [4] = '{3, 4, 10, 11};

  bank_one_sfr_map #(.ADDR_WIDTH(12)) dut (
    .clk(clk), .rst(rst), .reset_is_brown_out(reset_is_brown_out), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .indirect_rdata(indirect_rdata), .indirect_address(indirect_address), .indirect_write(indirect_write),
    .indirect_wdata(indirect_wdata), .alu_flags_we(alu_flags_we), .alu_flags(alu_flags),
    .power_flags_we(power_flags_we), .power_flags(power_flags), .osc_stable(osc_stable),
    .serial_status(serial_status), .conv_done(conv_done), .conv_result_low(conv_result_low),
    .jump_load(jump_load), .jump_target(jump_target), .pc_step(pc_step), .program_counter(program_counter),
    .port_a_drive_en(port_a_drive_en), .port_b_drive_en(port_b_drive_en),
    .timer_prescale_settings(o_b[0]), .core_flags_bank_select(o_b[1]), .core_interrupt_control(o_b[2]),
    .peripheral_irq_enable_one(o_b[3]), .peripheral_irq_enable_two(o_b[4]), .oscillator_select(o_b[5]),
    .internal_osc_trim(o_b[6]), .timer_two_period(o_b[7]), .serial_port_slave_address(o_b[8]),
    .conversion_config_one(o_b[9]));

  // ************************************************************
  // clock, timeout and helpers
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles >= 20000) begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  function automatic logic [7:0] exp_rd(input int i);
    case (i)
      0: exp_rd = indirect_rdata;
      2: exp_rd = pcm[7:0];
      15: exp_rd = m[i] | {5'h00, osc_stable, 2'h0};
      20: exp_rd = m[i] | {2'h0, serial_status};
      default: exp_rd = m[i];
    endcase
  endfunction

  task automatic apb(input logic wr, input logic [8:0] idx, input logic [7:0] d, output logic [7:0] r);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {1'b0, idx, 2'h0};
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata[7:0];
    `CHK("slave error", 1'b0, pslverr)
    if (!wr) `CHK("upper lanes", 24'h000000, prdata[31:8])
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr_reg(input logic [1:0] b, input int i, input logic [7:0] v);
    logic [7:0] r;
    apb(1'b1, {b, 7'(i)}, v, r);
    m[i] = (m[i] & ~wr_mask[i]) | (v & wr_mask[i]);
    kn[i] = kn[i] | wr_mask[i];
  endtask

  task automatic check_all();
    logic [7:0] r;
    for (int i = 0; i < 32; i++) begin
      apb(1'b0, {2'h1, 7'(i)}, 8'h00, r);
      `CHK("register read", exp_rd(i) & kn[i], r & kn[i])
      if (i == 5) `CHK("dir a pin five", 1'b1, r[5])
    end
    `CHK("port a drive", ~m[5] & 8'hDF, port_a_drive_en)
    `CHK("port b drive", ~m[6], port_b_drive_en)
    `CHK("prescale out", m[1], o_b[0])
    `CHK("enable one out", m[12], o_b[3])
    `CHK("period out", m[18], o_b[7])
    `CHK("config out", m[31], o_b[9])
    `CHK("flags out", m[3] & kn[3], o_b[1] & kn[3])
    `CHK("interrupt out", m[11] & kn[11], o_b[2] & kn[11])
    `CHK("enable two out", m[13], o_b[4])
    `CHK("oscillator out", exp_rd(15), o_b[5])
    `CHK("trim out", m[16], o_b[6])
    `CHK("slave address out", m[19], o_b[8])
  endtask

  task automatic do_reset(input logic bo);
    @(posedge clk);
    rst <= 1'b1;
    reset_is_brown_out <= bo;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 32; i++) begin
      m[i] = rst_val[i];
      kn[i] = (i == 3) ? 8'hF8 : (i == 11) ? 8'hFE : (i == 4 || i == 30) ? 8'h00 : 8'hFF;
    end
    m[14] = {6'h00, bo, ~bo};
    pcm = 13'h0000;
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    logic [7:0] r;
    logic [7:0] v;
    logic [7:0] d;
    int         seen;
    logic [8:0] ad;
    logic [7:0] wd;
    {rst, reset_is_brown_out, psel, penable, pwrite, alu_flags_we, power_flags_we} = 7'h40;
    {conv_done, jump_load, pc_step, osc_stable} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    {indirect_rdata, conv_result_low, alu_flags, power_flags, serial_status} = 27'h0000000;
    jump_target = 11'h000;
    mismatches = 0;
    cmp_count = 0;
    cycles = 0;
    void'($urandom(19767));
    do_reset(1'b0);
    check_all();
    osc_stable <= 1'b1;
    serial_status <= 6'($urandom);
    indirect_rdata <= 8'($urandom);
    repeat (2) begin
      for (int i = 1; i < 32; i++)
        if (i != 2) wr_reg(2'h1, i, 8'($urandom));
      check_all();
    end
    wr_reg(2'h1, 5, 8'h00);
    apb(1'b1, 9'h105, 8'h00, r);
    check_all();
    for (int b = 0; b < 4; b++) begin
      foreach (shared_idx[k]) begin
        wr_reg(2'(b), shared_idx[k], 8'($urandom));
        apb(1'b0, {2'(b + 1), 7'(shared_idx[k])}, 8'h00, r);
        `CHK("shared read", exp_rd(shared_idx[k]), r)
      end
    end
    v = 8'($urandom);
    d = 8'($urandom);
    wr_reg(2'h1, 10, v);
    apb(1'b1, 9'h082, d, r);
    pcm = {v[4:0], d};
    @(posedge clk);
    `CHK("counter load", pcm, program_counter)
    pc_step <= 1'b1;
    @(posedge clk);
    pc_step <= 1'b0;
    @(posedge clk);
    pcm = pcm + 13'h0001;
    `CHK("counter step", pcm, program_counter)
    jump_target <= 11'($urandom);
    jump_load <= 1'b1;
    @(posedge clk);
    jump_load <= 1'b0;
    @(posedge clk);
    pcm = {m[10][4:3], jump_target};
    `CHK("counter jump", pcm, program_counter)
    check_all();
    v = 8'($urandom);
    apb(1'b1, 9'h080, v, r);
    seen = 0;
    repeat (2) begin
      @(posedge clk);
      if (indirect_write === 1'b1) begin
        seen++;
        wd = indirect_wdata;
        ad = indirect_address;
      end
    end
    `CHK("indirect strobes", 1, seen)
    `CHK("indirect data", v, wd)
    `CHK("indirect address", {m[3][7], m[4]}, ad)
    conv_result_low <= 8'($urandom);
    alu_flags <= 3'($urandom);
    power_flags <= 2'($urandom);
    {conv_done, alu_flags_we, power_flags_we} <= 3'h7;
    @(posedge clk);
    {conv_done, alu_flags_we, power_flags_we} <= 3'h0;
    m[30] = conv_result_low;
    kn[30] = 8'hFF;
    m[3] = {m[3][7:5], power_flags, alu_flags};
    kn[3] = 8'hFF;
    check_all();
    do_reset(1'b1);
    check_all();
    report_and_stop();
  end
endmodule
